// >>> logic/hts_pkg.sv
`default_nettype none
package hts_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int MS_CYC = CLK_HZ / 1000; // cycles per millisecond
  localparam int BOOT_MS = 14; // boot time, kept under 15 ms
  localparam int SETUP_NS = 100; // data setup before clock release
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  // worst-case conversion times in ms
  localparam logic [7:0] T14_MS = 8'h55; // 85
  localparam logic [7:0] T13_MS = 8'h2B; // 43
  localparam logic [7:0] T12_MS = 8'h16; // 22
  localparam logic [7:0] T11_MS = 8'h0B; // 11
  localparam logic [7:0] H12_MS = 8'h1D; // 29
  localparam logic [7:0] H11_MS = 8'h0F; // 15
  localparam logic [7:0] H10_MS = 8'h09; // 9
  localparam logic [7:0] H8_MS = 8'h04; // 4
  // ==========================================================
  // bus address and commands
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic [7:0] CMD_T_HOLD = 8'hE3;
  localparam logic [7:0] CMD_H_HOLD = 8'hE5;
  localparam logic [7:0] CMD_T_POLL = 8'hF3;
  localparam logic [7:0] CMD_H_POLL = 8'hF5;
  localparam logic [7:0] CMD_WR_CFG = 8'hE6;
  localparam logic [7:0] CMD_RD_CFG = 8'hE7;
  localparam logic [7:0] CMD_SRST = 8'hFE;
  // ==========================================================
  // checksum
  localparam logic [7:0] CRC_POLY = 8'h31; // x^8 + x^5 + x^4 + 1
  localparam logic [7:0] CRC_INIT = 8'h00;
  // ==========================================================
  // user settings register
  typedef struct packed {
    logic res_hi;
    logic low_supply;
    logic [2:0] rsvd;
    logic heater;
    logic no_reload;
    logic res_lo;
  } hts_cfg_s;
  localparam logic [2:0] RSVD_DEF = 3'h7;
  localparam hts_cfg_s CFG_RST = '{1'b0, 1'b0, RSVD_DEF, 1'b0, 1'b1, 1'b0};
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_IDLE = 3'h1,
    ST_ADDR = 3'h2,
    ST_RX = 3'h3,
    ST_ACK = 3'h4,
    ST_TX = 3'h5,
    ST_TXACK = 3'h6,
    ST_HOLD = 3'h7
  } hts_state_e;
  // ==========================================================
  // helpers
  function automatic logic [7:0] conv_ms(input logic hum, input logic [1:0] res);
    case ({hum, res})
      3'h0: conv_ms = T14_MS;
      3'h1: conv_ms = T12_MS;
      3'h2: conv_ms = T13_MS;
      3'h3: conv_ms = T11_MS;
      3'h4: conv_ms = H12_MS;
      3'h5: conv_ms = H8_MS;
      3'h6: conv_ms = H10_MS;
      default: conv_ms = H11_MS;
    endcase
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// >>> logic/hts_sensor_if.sv
`timescale 1ns/100ps
`default_nettype none
module hts_sensor_if #(
  parameter int MS_CYC = hts_pkg::MS_CYC
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [15:0] temp_raw_i,
  input wire logic [15:0] humidity_reading_i,
  input wire logic supply_low_i,
  output logic heater_en_o,
  output logic idle_o,
  output logic conv_busy_o
);
  localparam logic [31:0] BOOT_CYC = 32'(hts_pkg::BOOT_MS * MS_CYC);
  localparam logic [3:0] SETUP_CYC = 4'(hts_pkg::SETUP_CYC);

  // ==========================================================
  // pin synchronisers and bus events
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic sup_s1_r, sup_s2_r;

  // two flops per pin, third on scl and sda for edge finding
  always_ff @(posedge sys_clk_i) begin
    scl_s1_r <= scl_i;
    scl_s2_r <= scl_s1_r;
    scl_d_r <= scl_s2_r;
    sda_s1_r <= sda_i;
    sda_s2_r <= sda_s1_r;
    sda_d_r <= sda_s2_r;
    sup_s1_r <= supply_low_i;
    sup_s2_r <= sup_s1_r;
  end

  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // ==========================================================
  // state
  hts_pkg::hts_state_e state_r;
  hts_pkg::hts_cfg_s cfg_r;
  hts_pkg::hts_cfg_s cfg_dflt;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] cmd_r;
  logic [1:0] byte_idx_r;
  logic ack_rd_r, tx_reg_r, wr_cfg_r, rst_pend_r, mack_r;
  logic conv_busy_r, conv_hold_r, conv_hum_r, res_valid_r;
  logic [1:0] conv_res_r;
  logic [31:0] cnt_r;
  logic [15:0] res_r;
  logic [7:0] crc_r;
  logic [3:0] setup_r;
  logic scl_oe_n_r, sda_oe_n_r, idle_r, drv0_r;

  // defaults with the heater bit carried over
  always_comb begin
    cfg_dflt = hts_pkg::CFG_RST;
    cfg_dflt.heater = cfg_r.heater;
  end

  // ==========================================================
  // decoding
  wire byte8 = scl_fall && (bit_cnt_r == 4'h8);
  wire addr_hit = sh_r[7:1] == hts_pkg::DEV_ADDR;
  wire hdr_rd = sh_r[0];
  wire rd_reg = cmd_r == hts_pkg::CMD_RD_CFG;
  wire rd_meas = (cmd_r == hts_pkg::CMD_T_HOLD) | (cmd_r == hts_pkg::CMD_H_HOLD)
    | (cmd_r == hts_pkg::CMD_T_POLL) | (cmd_r == hts_pkg::CMD_H_POLL);
  wire new_hold = (sh_r == hts_pkg::CMD_T_HOLD) | (sh_r == hts_pkg::CMD_H_HOLD);
  wire new_poll = (sh_r == hts_pkg::CMD_T_POLL) | (sh_r == hts_pkg::CMD_H_POLL);
  wire new_hum = (sh_r == hts_pkg::CMD_H_HOLD) | (sh_r == hts_pkg::CMD_H_POLL);
  wire rd_ok = rd_reg | (rd_meas & (res_valid_r | (conv_busy_r & conv_hold_r)));
  wire hdr_ack = addr_hit & (~hdr_rd | rd_ok);
  wire [1:0] cur_res = {cfg_r.res_hi, cfg_r.res_lo};
  wire [1:0] dflt_res = {hts_pkg::CFG_RST.res_hi, hts_pkg::CFG_RST.res_lo};
  wire [31:0] conv_lim = 32'(hts_pkg::conv_ms(conv_hum_r, conv_res_r)) * 32'(MS_CYC);
  wire [15:0] raw = conv_hum_r ? humidity_reading_i : temp_raw_i;
  wire [15:0] res_word = {raw[15:2], conv_hum_r, 1'b0};
  wire [1:0] ld_idx = (state_r == hts_pkg::ST_TXACK) ? byte_idx_r + 2'h1 : 2'h0;
  wire [7:0] ld_byte = tx_reg_r ? cfg_r : (ld_idx == 2'h0) ? res_r[15:8]
    : (ld_idx == 2'h1) ? res_r[7:0] : crc_r;

  // ==========================================================
  // bus engine, conversion timer and settings
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= hts_pkg::ST_BOOT;
      cfg_r <= hts_pkg::CFG_RST;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      byte_idx_r <= 2'h0;
      ack_rd_r <= 1'b0;
      tx_reg_r <= 1'b0;
      wr_cfg_r <= 1'b0;
      rst_pend_r <= 1'b0;
      mack_r <= 1'b0;
      conv_busy_r <= 1'b0;
      conv_hold_r <= 1'b0;
      conv_hum_r <= 1'b0;
      conv_res_r <= 2'h0;
      res_valid_r <= 1'b0;
      cnt_r <= 32'h0;
      res_r <= 16'h0000;
      crc_r <= 8'h00;
      setup_r <= 4'h0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      // conversion timer
      if (conv_busy_r) begin
        if (cnt_r >= conv_lim - 32'h1) begin
          conv_busy_r <= 1'b0;
          res_valid_r <= 1'b1;
          res_r <= res_word;
          crc_r <= hts_pkg::crc8(res_word);
          cfg_r.low_supply <= sup_s2_r;
        end else begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
      // clock release after data setup
      if (setup_r != 4'h0) begin
        setup_r <= setup_r - 4'h1;
        if (setup_r == 4'h1) begin
          scl_oe_n_r <= 1'b1;
        end
      end
      // bit counting and sampling
      if (scl_rise && (state_r == hts_pkg::ST_ADDR || state_r == hts_pkg::ST_RX)) begin
        sh_r <= {sh_r[6:0], sda_s2_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (scl_rise && state_r == hts_pkg::ST_TX) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      case (state_r)
        hts_pkg::ST_BOOT: begin
          if (cnt_r >= BOOT_CYC - 32'h1) begin
            state_r <= hts_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        hts_pkg::ST_ADDR: begin
          if (byte8) begin
            if (hdr_ack) begin
              state_r <= hts_pkg::ST_ACK;
              sda_oe_n_r <= 1'b0;
              ack_rd_r <= hdr_rd;
              tx_reg_r <= rd_reg;
            end else begin
              state_r <= hts_pkg::ST_IDLE;
            end
          end
        end
        hts_pkg::ST_RX: begin
          if (byte8) begin
            state_r <= hts_pkg::ST_ACK;
            sda_oe_n_r <= 1'b0;
            ack_rd_r <= 1'b0;
            if (wr_cfg_r) begin
              wr_cfg_r <= 1'b0;
              cfg_r.res_hi <= sh_r[7];
              cfg_r.heater <= sh_r[2];
              cfg_r.no_reload <= sh_r[1];
              cfg_r.res_lo <= sh_r[0];
            end else begin
              cmd_r <= sh_r;
              wr_cfg_r <= sh_r == hts_pkg::CMD_WR_CFG;
              rst_pend_r <= sh_r == hts_pkg::CMD_SRST;
              if (new_hold || new_poll) begin
                conv_busy_r <= 1'b1;
                conv_hold_r <= new_hold;
                conv_hum_r <= new_hum;
                res_valid_r <= 1'b0;
                cnt_r <= 32'h0;
                conv_res_r <= cfg_r.no_reload ? cur_res : dflt_res;
                if (!cfg_r.no_reload) begin
                  cfg_r <= cfg_dflt;
                end
              end
            end
          end
        end
        hts_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            bit_cnt_r <= 4'h0;
            byte_idx_r <= 2'h0;
            if (rst_pend_r) begin
              rst_pend_r <= 1'b0;
              state_r <= hts_pkg::ST_BOOT;
              cfg_r <= cfg_dflt;
              conv_busy_r <= 1'b0;
              res_valid_r <= 1'b0;
              cnt_r <= 32'h0;
            end else if (!ack_rd_r) begin
              state_r <= hts_pkg::ST_RX;
            end else if (tx_reg_r || res_valid_r) begin
              state_r <= hts_pkg::ST_TX;
              sda_oe_n_r <= ld_byte[7];
              sh_r <= {ld_byte[6:0], 1'b0};
              res_valid_r <= tx_reg_r & res_valid_r;
            end else begin
              state_r <= hts_pkg::ST_HOLD;
              scl_oe_n_r <= 1'b0;
            end
          end
        end
        hts_pkg::ST_HOLD: begin
          if (res_valid_r) begin
            res_valid_r <= 1'b0;
            state_r <= hts_pkg::ST_TX;
            sda_oe_n_r <= ld_byte[7];
            sh_r <= {ld_byte[6:0], 1'b0};
            setup_r <= SETUP_CYC;
          end
        end
        hts_pkg::ST_TX: begin
          if (byte8) begin
            sda_oe_n_r <= 1'b1;
            state_r <= hts_pkg::ST_TXACK;
          end else if (scl_fall) begin
            sda_oe_n_r <= sh_r[7];
            sh_r <= {sh_r[6:0], 1'b0};
          end
        end
        hts_pkg::ST_TXACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s2_r;
          end
          if (scl_fall) begin
            if (mack_r && !tx_reg_r && byte_idx_r != 2'h2) begin
              byte_idx_r <= ld_idx;
              bit_cnt_r <= 4'h0;
              state_r <= hts_pkg::ST_TX;
              sda_oe_n_r <= ld_byte[7];
              sh_r <= {ld_byte[6:0], 1'b0};
            end else begin
              state_r <= hts_pkg::ST_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
      // start and stop override everything outside boot and hold
      if (state_r != hts_pkg::ST_BOOT && state_r != hts_pkg::ST_HOLD) begin
        if (start_det) begin
          state_r <= hts_pkg::ST_ADDR;
          bit_cnt_r <= 4'h0;
          sda_oe_n_r <= 1'b1;
        end else if (stop_det) begin
          state_r <= hts_pkg::ST_IDLE;
          sda_oe_n_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      idle_r <= 1'b0;
      drv0_r <= 1'b0;
    end else begin
      idle_r <= (state_r == hts_pkg::ST_IDLE) && !conv_busy_r;
    end
  end

  assign scl_o = drv0_r;
  assign sda_o = drv0_r;
  assign scl_oe_n_o = scl_oe_n_r;
  assign sda_oe_n_o = sda_oe_n_r;
  assign heater_en_o = cfg_r.heater;
  assign idle_o = idle_r;
  assign conv_busy_o = conv_busy_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_boot_time_bound: assert property (
    state_r == hts_pkg::ST_BOOT |-> cnt_r < BOOT_CYC && sda_oe_n_r)
    else $error("boot overran or drove data");
  a_idle_sleep_flag: assert property (
    state_r == hts_pkg::ST_IDLE && !conv_busy_r |=> idle_o)
    else $error("idle flag missing");
  a_addr_miss_nack: assert property (
    state_r == hts_pkg::ST_ADDR && byte8 && !addr_hit && !start_det && !stop_det
      |=> state_r == hts_pkg::ST_IDLE && sda_oe_n_r)
    else $error("foreign address acknowledged");
  a_rx_ack_drive: assert property (
    state_r == hts_pkg::ST_RX && byte8 && !start_det && !stop_det
      |=> !sda_oe_n_r && state_r == hts_pkg::ST_ACK)
    else $error("byte not acknowledged");
  a_hold_scl_low: assert property (
    state_r == hts_pkg::ST_HOLD |-> !scl_oe_n_r)
    else $error("clock released during hold");
  a_poll_busy_nack: assert property (
    state_r == hts_pkg::ST_ADDR && byte8 && addr_hit && hdr_rd && rd_meas
      && !res_valid_r && !conv_hold_r && !start_det && !stop_det
      |=> sda_oe_n_r ##1 sda_oe_n_r)
    else $error("poll acknowledged before result");
  a_status_bits: assert property (
    $rose(res_valid_r) |-> res_r[1] == conv_hum_r && !res_r[0])
    else $error("status bits wrong");
  a_crc_skip_nack: assert property (
    state_r == hts_pkg::ST_TXACK && scl_fall && !mack_r && !start_det && !stop_det
      |=> state_r == hts_pkg::ST_IDLE)
    else $error("transmit continued after nack");
  a_conv_time: assert property (
    conv_busy_r |-> cnt_r < conv_lim)
    else $error("conversion overran its time");
  a_heater_kept: assert property (
    state_r == hts_pkg::ST_BOOT |=> $stable(cfg_r.heater))
    else $error("heater changed by reboot");
  a_crc_of_result: assert property (
    $rose(res_valid_r) |-> crc_r == hts_pkg::crc8(res_r))
    else $error("checksum mismatch");

  c_hold_read: cover property (state_r == hts_pkg::ST_HOLD ##1 state_r == hts_pkg::ST_TX);
  c_poll_nack: cover property (state_r == hts_pkg::ST_ADDR && byte8 && addr_hit && !hdr_ack);
  c_cfg_write: cover property (state_r == hts_pkg::ST_RX && byte8 && wr_cfg_r);
  c_soft_reset: cover property (state_r == hts_pkg::ST_ACK && scl_fall && rst_pend_r);
endmodule
`default_nettype wire

// >>> testbench/hts_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host bus master model
module hts_host (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  int stall;
  logic r;
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // wait n cycles, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // release clock, honour device stretch
  task automatic rise();
    scl_low_o = 1'b0;
    cyc(2);
    stall = 0;
    while (scl_i !== 1'b1 && stall < 20000) begin
      @(posedge clk_i);
      stall++;
    end
    #1;
  endtask
  // one bit, 4 cycles low then 4 high
  task automatic clk_bit(input logic b, output logic s);
    cyc(2);
    sda_low_o = ~b;
    cyc(2);
    rise();
    repeat (2) @(posedge clk_i);
    s = sda_i;
    #1;
    scl_low_o = 1'b1;
  endtask
  // start, repeated or from idle
  task automatic start();
    cyc(2);
    sda_low_o = 1'b0;
    cyc(2);
    rise();
    cyc(2);
    sda_low_o = 1'b1;
    cyc(4);
    scl_low_o = 1'b1;
  endtask
  task automatic stop();
    cyc(2);
    sda_low_o = 1'b1;
    cyc(2);
    rise();
    cyc(2);
    sda_low_o = 1'b0;
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(~ack, r);
  endtask
endmodule
`default_nettype wire

// >>> testbench/humidity_temp_sensor_i2c_cmd_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench top
module humidity_temp_sensor_i2c_cmd_tb;
  localparam int MSC = 40; // keeps shortest conversion longer than one poll header
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, heater_en_o, idle_o, conv_busy_o;
  logic h_scl, h_sda, ack, supply_low;
  logic [15:0] temp_raw = 16'h0000;
  logic [15:0] hum_raw = 16'h0000;
  logic [7:0] d;
  logic [7:0] cfg_m;
  logic [7:0] cmds [4] = '{8'hE3, 8'hE5, 8'hF3, 8'hF5};
  logic [31:0] rng = 32'd94;
  int tt [4] = '{85, 22, 43, 11};
  int ht [4] = '{29, 4, 9, 15};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int busy_len = 0;
  int last_len = 0;
  // wired-and bus with pull-ups
  wire scl = ~(h_scl | (~scl_oe_n_o & ~scl_o));
  wire sda = ~(h_sda | (~sda_oe_n_o & ~sda_o));
  initial begin
    supply_low = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  hts_sensor_if #(.MS_CYC(MSC)) dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .temp_raw_i(temp_raw), .humidity_reading_i(hum_raw),
    .supply_low_i(supply_low), .heater_en_o(heater_en_o), .idle_o(idle_o),
    .conv_busy_o(conv_busy_o));
  hts_host host (.clk_i(sys_clk_i), .scl_i(scl), .sda_i(sda), .scl_low_o(h_scl),
    .sda_low_o(h_sda));
  // busy length and hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (conv_busy_o === 1'b1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      last_len = busy_len;
      busy_len = 0;
    end
    if (cycles > 40000) begin
      errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // bitwise checksum model
  function automatic logic [7:0] crc_m(input logic [15:0] v);
    int c;
    c = 0;
    for (int i = 15; i >= 0; i--) begin
      c = ((c >> 7) & 1) != v[i] ? (((c << 1) & 255) ^ 'h31) : ((c << 1) & 255);
    end
    return c[7:0];
  endfunction
  task automatic note(input string n, input string e, input string g);
    errors++;
    $display("mismatch %s expected %s seen %s", n, e, g);
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) note(n, $sformatf("%h", e), $sformatf("%h", g));
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) note(n, $sformatf("%b", e), $sformatf("%b", g));
  endtask
  task automatic chk_len(input int e, input int g);
    total_checks++;
    if (g < e - 3 || g > e + 3) note("busy", $sformatf("%0d", e), $sformatf("%0d", g));
  endtask
  task automatic hdr(input logic [7:0] h, input logic e);
    host.start();
    host.wr(h, ack);
    chk1("header ack", e, ack);
  endtask
  task automatic cmd(input logic [7:0] c);
    hdr(8'h80, 1'b1);
    host.wr(c, ack);
    chk1("command ack", 1'b1, ack);
  endtask
  task automatic rd_cfg();
    cmd(8'hE7);
    hdr(8'h81, 1'b1);
    host.rd(1'b0, d);
    chk8("settings", cfg_m, d);
    host.stop();
  endtask
  task automatic wr_cfg(input logic [7:0] v);
    cmd(8'hE6);
    host.wr(v, ack);
    chk1("data ack", 1'b1, ack);
    host.stop();
    cfg_m = (v & 8'h87) | (cfg_m & 8'h78);
  endtask
  task automatic measure(input logic [7:0] c);
    logic [15:0] w;
    logic [31:0] t;
    int ms;
    t = xs();
    temp_raw = t[15:0];
    hum_raw = t[31:16];
    t = xs();
    supply_low = t[0];
    if (cfg_m[1] === 1'b0) cfg_m = 8'h3A | (cfg_m & 8'h04);
    ms = c[2] ? ht[{cfg_m[7], cfg_m[0]}] : tt[{cfg_m[7], cfg_m[0]}];
    w = {(c[2] ? hum_raw[15:2] : temp_raw[15:2]), c[2], 1'b0};
    cmd(c);
    if (!c[4]) begin
      hdr(8'h81, 1'b1);
    end else begin
      host.stop();
      hdr(8'h81, 1'b0);
      host.stop();
      t = 0;
      while (conv_busy_o !== 1'b0 && t < 4000) begin
        @(posedge sys_clk_i);
        t++;
      end
      host.cyc(4);
      hdr(8'h81, 1'b1);
    end
    host.rd(1'b1, d);
    chk8("result msb", w[15:8], d);
    host.rd(!c[4], d);
    chk8("result lsb", w[7:0], d);
    if (!c[4]) begin
      host.rd(1'b0, d);
      chk8("checksum", crc_m(w), d);
    end
    if (c[4]) host.cyc(1 + MSC / 50);
    host.stop();
    chk_len(ms * MSC, last_len);
    cfg_m[6] = supply_low;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] t;
    repeat (3) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    hdr(8'h80, 1'b0);
    host.stop();
    host.cyc(15 * MSC - 20);
    chk1("idle", 1'b1, idle_o);
    cfg_m = 8'h3A;
    rd_cfg();
    hdr(8'h82, 1'b0);
    host.stop();
    for (int i = 0; i < 4; i++) begin
      t = xs();
      wr_cfg({t[1], 1'b1, d[5:3], t[2], 1'b1, t[0]});
      chk1("heater", t[2], heater_en_o);
      measure(cmds[i]);
      rd_cfg();
    end
    wr_cfg(8'hBD);
    measure(8'hE3);
    rd_cfg();
    wr_cfg(8'hBF);
    cmd(8'hFE);
    host.stop();
    host.cyc(15 * MSC - 20);
    cfg_m = 8'h3E;
    rd_cfg();
    chk1("heater", 1'b1, heater_en_o);
    report_and_stop();
  end
endmodule
`default_nettype wire
